//--- otxc_defs.svh
`ifndef OTXC_DEFS_SVH
`define OTXC_DEFS_SVH

// ****************************************************************
// Constants of the optical transmit control block.
// ****************************************************************

`define OTXC_CHANNELS 4
`define OTXC_LIGHT_ON 1'b1
`define OTXC_LIGHT_OFF 1'b0
`define OTXC_FAULT_IDLE_N 1'b1
`define OTXC_FAULT_SET_N 1'b0
`define OTXC_CAUSE_OVERCURRENT 0
`define OTXC_CAUSE_TEMPERATURE 1
`define OTXC_CAUSE_CALIBRATION 2
`define OTXC_CAUSE_WIDTH 3
`define OTXC_CAUSE_NONE 3'h0

`endif

//--- otxc_pkg.sv
`include "otxc_defs.svh"

package otxc_pkg;

  // ****************************************************************
  // Types shared by the block and its helpers.
  // ****************************************************************

  // Host control levels, grouped as they travel together.
  typedef struct packed {
    logic tx_off_request;
    logic tx_on_request;
    logic tx_reset_n;
  } otxc_ctrl_type;

  // State of the transmitter.
  typedef enum logic [1:0] {
    OTXC_HELD,
    OTXC_LIT,
    OTXC_FAULTED
  } otxc_state_type;

endpackage

//--- otxc_fault_latch.sv
`timescale 1ns/1ps
`include "otxc_defs.svh"

// Holds a transmitter fault until a reset or an enable toggle clears it.
module otxc_fault_latch
  import otxc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [`OTXC_CAUSE_WIDTH-1:0] i_cause,
  input wire logic i_clear,
  output logic o_fault_n,
  output logic [`OTXC_CAUSE_WIDTH-1:0] o_cause_q
);

  logic latched_q;

  // ****************************************************************
  // Latch.
  // ****************************************************************

  // A cause in the same cycle as a clear wins, so no fault slips past.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      latched_q <= 1'b0;
      o_cause_q <= `OTXC_CAUSE_NONE;
    end else if (|i_cause) begin
      latched_q <= 1'b1; // [R4] [R6]
      o_cause_q <= o_cause_q | i_cause;
    end else if (i_clear) begin
      latched_q <= 1'b0; // [R6] [R11]
      o_cause_q <= `OTXC_CAUSE_NONE;
    end
  end

  // Fault output register; high means the transmitter is healthy.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fault_n <= `OTXC_FAULT_IDLE_N;
    end else if (|i_cause) begin
      o_fault_n <= `OTXC_FAULT_SET_N; // [R4]
    end else if (i_clear) begin
      o_fault_n <= `OTXC_FAULT_IDLE_N; // [R5]
    end else begin
      o_fault_n <= latched_q ? `OTXC_FAULT_SET_N : `OTXC_FAULT_IDLE_N;
    end
  end

  fault_holds_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!o_fault_n && ~|i_cause && !i_clear) |=> !o_fault_n) // [R6]
    else $error("fault released without a clear");

endmodule

//--- otxc_rx_detect.sv
`timescale 1ns/1ps
`include "otxc_defs.svh"

// Combines per-channel light detection and squelches the receive data.
module otxc_rx_detect
  import otxc_pkg::*;
#(
  parameter int CHANNELS = `OTXC_CHANNELS
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [CHANNELS-1:0] i_rx_light,
  input wire logic [CHANNELS-1:0] i_rx_data,
  output logic o_rx_light_present,
  output logic [CHANNELS-1:0] o_rx_data
);

  // ****************************************************************
  // Detect and squelch.
  // ****************************************************************

  // Data is gated with the same term as the detect flag, so both move together.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rx_light_present <= 1'b0;
      o_rx_data <= '0;
    end else begin
      o_rx_light_present <= &i_rx_light; // [R8]
      o_rx_data <= (&i_rx_light) ? i_rx_data : '0; // [R9]
    end
  end

  squelch_tracks_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_rx_light_present |-> o_rx_data == '0) // [R9]
    else $error("receive data not squelched");

  detect_all_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(&i_rx_light) |=> !o_rx_light_present) // [R8]
    else $error("detect high with a channel dark");

endmodule

//--- otxc_top.sv
`timescale 1ns/1ps
`include "otxc_defs.svh"

// ****************************************************************
// Optical transmit control and receive status.
// ****************************************************************

// Overview of operation
// [R1]: Transmit-off high turns every emitter off; low allows normal running.
// [R2]: Transmit-off has a pull-down, so an undriven pin means run.
// [R3]: Transmit-on low keeps emitters off; high permits operation.
// [R4]: Over-current, temperature or calibration corruption drives fault output low.
// [R5]: Without fault the fault output stays high.
// [R6]: A fault disables emitters and stays latched until transmitter reset.
// [R7]: Reset input low resets transmitter and keeps emitters off.
// [R8]: Signal detect high only when every receive channel sees light.
// [R9]: Receive data squelched whenever signal detect is low.
// [R10]: Transmit-off acts as the complement of transmit-on.
// [R11]: Toggling transmit-on also clears a latched fault.
// [R12]: Emitters lit only with on high, off low, reset high, no fault.
module otxc_top
  import otxc_pkg::*;
#(
  parameter int CHANNELS = `OTXC_CHANNELS
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tx_off_request,
  input wire logic i_tx_off_driven,
  input wire logic i_tx_on_request,
  input wire logic i_tx_reset_n,
  input wire logic i_overcurrent,
  input wire logic i_over_temperature,
  input wire logic i_calibration_bad,
  input wire logic [CHANNELS-1:0] i_rx_light,
  input wire logic [CHANNELS-1:0] i_rx_data,
  output logic [CHANNELS-1:0] o_emitter_on,
  output logic o_tx_fault_n,
  output logic [`OTXC_CAUSE_WIDTH-1:0] o_fault_cause,
  output logic o_rx_light_present,
  output logic [CHANNELS-1:0] o_rx_data
);

  otxc_ctrl_type ctrl;
  otxc_state_type state_q;
  logic on_prev_q;
  logic on_rise;
  logic clear_fault;
  logic [`OTXC_CAUSE_WIDTH-1:0] cause;
  logic fault_n;
  logic permit;

  // Emitters may light only when every control agrees and no fault holds them off.
  // Kept in one place so that the drive logic reads as a single eye-safety gate.
  function automatic logic lit_allowed(input logic allow,
      input logic [`OTXC_CAUSE_WIDTH-1:0] why, input otxc_state_type now);
    lit_allowed = allow & ~|why & (now != OTXC_FAULTED);
  endfunction

  // ****************************************************************
  // Host controls.
  // ****************************************************************

  // An undriven off pin reads low, as its pull-down would make it.
  // The pull-down itself is analogue, so the host tells us whether it drives the pin.
  // A floating pin therefore never blocks the emitters, whatever level it shows.
  always_comb begin
    ctrl.tx_off_request = i_tx_off_driven & i_tx_off_request; // [R2]
    ctrl.tx_on_request = i_tx_on_request;
    ctrl.tx_reset_n = i_tx_reset_n;
  end

  // Either pin may steer the emitters; they act as complements. [R10]
  assign permit = ctrl.tx_on_request & ~ctrl.tx_off_request & ctrl.tx_reset_n; // [R10]

  // Remember the enable to spot a low-to-high toggle.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= permit;
    end
  end

  // A held reset or a re-enable after a drop clears the fault.
  assign on_rise = permit & ~on_prev_q; // [R11]
  assign clear_fault = ~ctrl.tx_reset_n | on_rise; // [R7] [R11]

  // ****************************************************************
  // Fault causes.
  // ****************************************************************

  // Each analogue monitor owns one bit of the cause vector.
  // The monitors are level inputs, so a cause that persists keeps the fault latched through a clear.
  always_comb begin
    cause = `OTXC_CAUSE_NONE;
    cause[`OTXC_CAUSE_OVERCURRENT] = i_overcurrent; // [R4]
    cause[`OTXC_CAUSE_TEMPERATURE] = i_over_temperature; // [R4]
    cause[`OTXC_CAUSE_CALIBRATION] = i_calibration_bad; // [R4]
  end

  // The latch keeps the fault and its causes until the host clears them.
  // A clear that meets a live cause is ignored there, so a fault cannot be lost.
  otxc_fault_latch u_fault (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cause(cause),
    .i_clear(clear_fault),
    .o_fault_n(fault_n),
    .o_cause_q(o_fault_cause)
  );

  // The top output is its own flop, one cycle behind the latch.
  // The extra cycle only delays the report; the emitters are cut without waiting for it.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_tx_fault_n <= `OTXC_FAULT_IDLE_N;
    end else begin
      o_tx_fault_n <= fault_n; // [R4] [R5]
    end
  end

  // ****************************************************************
  // Transmitter state.
  // ****************************************************************

  // A fresh cause forces the faulted state at once, on the same edge as the latch output.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= OTXC_HELD;
    end else begin
      case (state_q)
        // Dark but healthy; waits for every control to allow light.
        OTXC_HELD: begin
          if (|cause) begin
            state_q <= OTXC_FAULTED; // [R6]
          end else if (permit) begin
            state_q <= OTXC_LIT; // [R12]
          end
        end
        // Lit; any cause or any control dropping takes the light away.
        OTXC_LIT: begin
          if (|cause) begin
            state_q <= OTXC_FAULTED; // [R6]
          end else if (!permit) begin
            state_q <= OTXC_HELD; // [R1] [R3] [R7]
          end
        end
        // Faulted; only a clear with every cause gone leaves this state.
        OTXC_FAULTED: begin
          if (~|cause && clear_fault) begin
            state_q <= OTXC_HELD; // [R6] [R11]
          end
        end
        default: begin
          state_q <= OTXC_HELD;
        end
      endcase
    end
  end

  // Emitter drive; off at the first edge after a cause appears, for eye safety.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_emitter_on <= {CHANNELS{`OTXC_LIGHT_OFF}};
    end else if (lit_allowed(permit, cause, state_q)) begin
      o_emitter_on <= {CHANNELS{`OTXC_LIGHT_ON}}; // [R12]
    end else begin
      o_emitter_on <= {CHANNELS{`OTXC_LIGHT_OFF}}; // [R1] [R3] [R6] [R7]
    end
  end

  // ****************************************************************
  // Receive side.
  // ****************************************************************

  // The receive path is independent of the transmitter state.
  // Loss of light squelches data in the same cycle as the detect flag falls.
  otxc_rx_detect #(
    .CHANNELS(CHANNELS)
  ) u_rx (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_rx_light(i_rx_light),
    .i_rx_data(i_rx_data),
    .o_rx_light_present(o_rx_light_present),
    .o_rx_data(o_rx_data)
  );

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // These checks watch the outputs and state that this block drives.
  // Most are one cycle behind their cause, because every output is registered.
  // Some use the controls as the block decodes them, others the pins as they show them.

  // An active off request darkens the emitters at the next edge.
  off_dark_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ctrl.tx_off_request |=> o_emitter_on == '0) // [R1]
    else $error("emitters lit while off requested");

  // A floating off pin must not hold the emitters dark.
  undriven_runs_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_tx_off_driven && i_tx_on_request && i_tx_reset_n && state_q == OTXC_LIT
     && ~|cause) |=> o_emitter_on != '0) // [R2]
    else $error("undriven off pin stopped the emitters");

  // A low enable darkens the emitters at the next edge.
  on_low_dark_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_tx_on_request |=> o_emitter_on == '0) // [R3]
    else $error("emitters lit with enable low");

  // The fault pin falls two edges after the cause, one for each flop.
  fault_out_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (|cause) |-> ##2 !o_tx_fault_n) // [R4]
    else $error("fault cause not reported in two cycles");

  // The cause register reports a fresh cause one edge later.
  cause_report_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (|cause) |=> o_fault_cause != '0) // [R4]
    else $error("fault cause not recorded");

  // A healthy lit transmitter keeps the fault pin high.
  idle_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_q == OTXC_LIT && ~|cause) |=> ##1 o_tx_fault_n) // [R5]
    else $error("fault output low without a fault");

  // The lit state is only reached after the fault pin has recovered.
  lit_clean_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_q == OTXC_LIT |-> o_tx_fault_n) // [R5]
    else $error("lit while the fault pin is low");

  // The emitters are already dark on the first faulted cycle.
  fault_dark_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_q == OTXC_FAULTED && !$past(state_q == OTXC_FAULTED) |-> o_emitter_on == '0) // [R6]
    else $error("emitters lit after fault");

  // The emitters stay dark for as long as the fault is held.
  faulted_dark_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_q == OTXC_FAULTED |=> o_emitter_on == '0) // [R6]
    else $error("emitters lit while faulted");

  // A live cause always leaves the transmitter faulted, clear or not.
  cause_wins_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (|cause) |=> state_q == OTXC_FAULTED) // [R6]
    else $error("fault cause did not hold the fault");

  // Recorded causes stay put until a clear without a cause.
  cause_sticky_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_fault_cause != '0 && ~|cause && !clear_fault) |=> $stable(o_fault_cause)) // [R6]
    else $error("fault cause changed without a clear");

  // A clear without a cause empties the cause register.
  cause_cleared_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_fault_cause != '0 && ~|cause && clear_fault) |=> o_fault_cause == '0) // [R6] [R11]
    else $error("fault cause kept after a clear");

  // A held transmitter reset keeps the emitters dark.
  reset_dark_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_tx_reset_n ##1 !i_tx_reset_n |-> o_emitter_on == '0) // [R7]
    else $error("emitters lit during transmitter reset");

  // The transmitter reset releases a fault once every cause has gone.
  reset_clears_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_q == OTXC_FAULTED && !ctrl.tx_reset_n && ~|cause) |=> state_q == OTXC_HELD) // [R7]
    else $error("transmitter reset did not clear the fault");

  // Light needs both control pins in their run levels.
  complement_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_emitter_on != '0) |-> $past(permit)) // [R10]
    else $error("emitters lit against a control pin");

  // A rising enable clears a fault once every cause has gone.
  toggle_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_q == OTXC_FAULTED && on_rise && ~|cause) |=> state_q == OTXC_HELD) // [R11]
    else $error("enable toggle did not clear the fault");

  // Light needs every condition at once in the cycle before.
  lit_needs_all_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_emitter_on != '0) |-> $past(permit && ~|cause && state_q != OTXC_FAULTED)) // [R12]
    else $error("emitters lit without every condition");

  // Main scenarios: light, fault, recovery, reset clear and receive detect.
  lit_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_emitter_on != '0);
  reset_clear_c: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_q == OTXC_FAULTED && !ctrl.tx_reset_n && ~|cause);
  fault_c: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_q == OTXC_LIT ##1 state_q == OTXC_FAULTED);
  recover_c: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_q == OTXC_FAULTED ##1 state_q == OTXC_HELD ##[1:4] state_q == OTXC_LIT);
  detect_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_rx_light_present);

endmodule

//--- otxc_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Host board control logic that drives the module control pins.
// ****************************************************************

// With the off pin chosen the on pin is held high; otherwise the off pin floats or drives the complement of run.
module otxc_host_model
  import otxc_pkg::*;
(
  input wire logic i_run,
  input wire logic i_use_off_pin,
  input wire logic i_off_floating,
  input wire logic i_reset_req,
  output otxc_ctrl_type o_ctrl,
  output logic o_off_driven
);
  // A released off pin shows a high level, so only the pull-down can make it read low.
  always_comb begin
    o_ctrl.tx_on_request = i_use_off_pin ? 1'b1 : i_run;
    o_ctrl.tx_off_request = i_off_floating ? 1'b1 : !i_run;
    o_ctrl.tx_reset_n = !i_reset_req;
    o_off_driven = !i_off_floating;
  end
endmodule

//--- otxc_top_tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench of the transmit control block.
// ****************************************************************

module otxc_top_tb;
  import otxc_pkg::*;
  logic clk, nrst, run, use_off, off_float, rst_req, oc, ot, cal, fault_n, present, off_driven;
  logic [3:0] light, data, emit, rxd;
  logic [2:0] cause;
  otxc_ctrl_type ctrl;
  int num_errors, checks_done, cycles;

  otxc_host_model u_otxc_host_model (.i_run(run), .i_use_off_pin(use_off),
    .i_off_floating(off_float), .i_reset_req(rst_req), .o_ctrl(ctrl),
    .o_off_driven(off_driven));

  otxc_top u_otxc_top (.i_clk(clk), .i_nrst(nrst), .i_tx_off_request(ctrl.tx_off_request),
    .i_tx_off_driven(off_driven), .i_tx_on_request(ctrl.tx_on_request),
    .i_tx_reset_n(ctrl.tx_reset_n), .i_overcurrent(oc), .i_over_temperature(ot),
    .i_calibration_bad(cal), .i_rx_light(light), .i_rx_data(data), .o_emitter_on(emit),
    .o_tx_fault_n(fault_n), .o_fault_cause(cause), .o_rx_light_present(present),
    .o_rx_data(rxd));

  // Free-running clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang is cut short well after the tests should have ended.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Inputs move on falling edges, so one wait spans exactly one sampling edge.
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Each enable pin on its own, then the transmitter reset.
  task automatic t_control();
    use_off = 1'b0; off_float = 1'b1; run = 1'b1; wait_n(1);
    check({4'h0, emit}, 8'h0F);
    run = 1'b0; wait_n(1);
    check({4'h0, emit}, 8'h00);
    off_float = 1'b0; run = 1'b1; wait_n(1);
    check({4'h0, emit}, 8'h0F);
    use_off = 1'b1; run = 1'b0; wait_n(1);
    check({4'h0, emit}, 8'h00);
    run = 1'b1; wait_n(1);
    check({4'h0, emit}, 8'h0F);
    rst_req = 1'b1; wait_n(1);
    check({4'h0, emit}, 8'h00);
    check({7'h00, fault_n}, 8'h01);
    rst_req = 1'b0; wait_n(1);
    check({4'h0, emit}, 8'h0F);
  endtask

  // One fault cause; a clear while it is present must not take.
  task automatic t_fault(input int idx);
    use_off = 1'b0;
    {cal, ot, oc} = 3'h1 << idx; wait_n(1);
    check({4'h0, emit}, 8'h00);
    check({5'h00, cause}, 8'h01 << idx);
    wait_n(1);
    check({7'h00, fault_n}, 8'h00);
    rst_req = 1'b1; wait_n(1);
    rst_req = 1'b0; wait_n(3);
    check({7'h00, fault_n}, 8'h00);
    {cal, ot, oc} = 3'h0; wait_n(3);
    check({7'h00, fault_n}, 8'h00);
    check({4'h0, emit}, 8'h00);
    if (idx == 2) begin
      run = 1'b0; wait_n(1);
      run = 1'b1; wait_n(3);
    end else begin
      rst_req = 1'b1; wait_n(1);
      rst_req = 1'b0; wait_n(3);
    end
    check({7'h00, fault_n}, 8'h01);
    check({5'h00, cause}, 8'h00);
    check({4'h0, emit}, 8'h0F);
  endtask

  // Every channel goes dark in turn while data keeps arriving.
  task automatic t_rx();
    light = 4'hF; data = 4'h5; wait_n(1);
    check({7'h00, present}, 8'h01);
    check({4'h0, rxd}, 8'h05);
    for (int i = 0; i < 4; i++) begin
      light = 4'hF & ~(4'h1 << i); wait_n(1);
      check({7'h00, present}, 8'h00);
      check({4'h0, rxd}, 8'h00);
    end
    light = 4'hF; data = 4'hA; wait_n(1);
    check({4'h0, rxd}, 8'h0A);
  endtask

  // Main sequence after ten cycles of reset.
  initial begin
    nrst = 1'b0; run = 1'b0; use_off = 1'b0; off_float = 1'b0; rst_req = 1'b0;
    oc = 1'b0; ot = 1'b0; cal = 1'b0; light = 4'h0; data = 4'h0;
    wait_n(10);
    nrst = 1'b1; wait_n(1);
    check({7'h00, fault_n}, 8'h01);
    check({4'h0, emit}, 8'h00);
    t_control();
    for (int k = 0; k < 3; k++) begin
      t_fault(k);
    end
    t_rx();
    wrap_up();
  end
endmodule
